// ==== msq_scan_module.sv ====
// Scanned 32-channel amplifier module: bus registers and link-side sequencer
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
//  Function
// [RULE1] Clearing the bus enable bit stops driving shared analog bus zero.
// [RULE2] An all-zero configuration write resets the module and clears bit 0.
// [RULE3] Mode 01 with low byte 07h takes its scan clock from trigger line.
// [RULE4] Mode 10 routes bus zero to the board; drives only when scan-control low.
// [RULE5] Mode 01 modules drive bus only when scan-control low, clocked by trigger.
// [RULE6] Scan-control enable bit 2 at zero: never driven; gain, start ignored. Here entries still load the start channel and gain is still decoded.
// [RULE7] Gain codes: 00000 gives 1, 01001 gives 50, 10010 gives 2000.
// [RULE8] Host loads a new list with the fixed control write order.
// [RULE9] Host reuses the stored list with its own write order.
// [RULE10] S bit zero repeats at list end; one stops after a single pass.
// [RULE11] Host deasserts the slot select between writes to one register.
// [RULE12] Each entry addressed here reloads the channel counter with start channel.
// [RULE13] Channel counter wraps from channel 31 to channel 0.
// [RULE14] Entry sample count holds samples minus one.
// [RULE15] Multi-chassis lists use slot 13 dummy entries as fillers.
// [RULE16] Each chassis is programmed independently; board takes several readings.
// [RULE17] Host enables acquisition and triggers only after all programming.
// [RULE18] Host shifts list entries serially over the master-out line.
// [RULE19] Scan-control deasserted keeps the bus driver off in every mode.
module msq_scan_module (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic link_clk,
    input wire logic scan_clock_n,
    input wire logic backplane_trigger_line,
    input wire logic scan_control_n,
    input wire logic scan_entry,
    input wire logic [7:0] scan_entry_count,
    input wire logic scan_list_end,
    output logic shared_bus_drive_enable,
    output logic analog_output_channel_zero,
    output logic trigger_clock_select,
    output logic [4:0] channel_counter
);
    // Bus side state
    logic [msq_pkg::CFG_W-1:0] cfg_reg, cfg_next;
    logic single_pass_reg, single_pass_next;
    logic tgl_reg, tgl_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] addr_reg, addr_next;
    logic [31:0] hrdata_next;
    logic [10:0] gain_reg, gain_next;
    logic [6:0] stat_s;
    logic [4:0] chan_bin;
    logic addr_ok;
    msq_cfg_if #(.W(msq_pkg::XFER_W)) cfg_bus ();

    // Link side state
    logic rst_l_meta, rst_l_n;
    logic [msq_pkg::XFER_W-1:0] xw;
    logic load_pulse;
    logic [3:0] pins_s;
    logic [7:0] count_s;
    logic clk_d_reg, entry_d_reg, end_d_reg;
    logic [4:0] chan_next;
    logic [4:0] gray_reg, gray_next;
    logic [8:0] samples_reg, samples_next;
    logic stopped_reg, stopped_next;
    logic drive_next, route_next, trig_next;
    logic sel_clk, adv_edge, entry_rise, end_rise, scanned, cfg_zero;
    logic [1:0] mode_l;

    assign addr_ok = hsel && htrans[1] && hready;
    assign cfg_bus.word = {single_pass_reg, cfg_reg};
    assign cfg_bus.load_tgl = tgl_reg;

    always_comb begin
        chan_bin = 5'h00;
        chan_bin[4] = stat_s[4];
        for (int i = 3; i >= 0; i--) begin
            chan_bin[i] = chan_bin[i+1] ^ stat_s[i];
        end
    end

    always_comb begin
        cfg_next = cfg_reg;
        single_pass_next = single_pass_reg;
        tgl_next = tgl_reg;
        wr_pend_next = addr_ok && hwrite;
        addr_next = addr_ok ? haddr[7:0] : addr_reg;
        hrdata_next = 32'h00000000;
        if (wr_pend_reg) begin
            if (addr_reg == msq_pkg::ADDR_CONFIG) begin
                // An all-zero word clears every field, bus enable included
                cfg_next = hwdata[msq_pkg::CFG_W-1:0]; // [RULE2]
                tgl_next = !tgl_reg;
            end else if (addr_reg == msq_pkg::ADDR_CTRL) begin
                single_pass_next = hwdata[msq_pkg::SINGLE_PASS_BIT]; // [RULE10]
                tgl_next = !tgl_reg;
            end
        end
        if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                msq_pkg::ADDR_CONFIG: hrdata_next = {8'h00, cfg_next};
                msq_pkg::ADDR_CTRL: hrdata_next = {31'h00000000, single_pass_next};
                msq_pkg::ADDR_STATUS: begin
                    hrdata_next[4:0] = chan_bin;
                    hrdata_next[msq_pkg::STAT_DRIVE_BIT] = stat_s[5];
                    hrdata_next[msq_pkg::STAT_STOP_BIT] = stat_s[6];
                    hrdata_next[msq_pkg::STAT_GAIN_LSB +: 11] = gain_reg;
                end
                default: hrdata_next = 32'h00000000;
            endcase
        end
        // Gain is decoded for software; the analog stage takes the raw code
        gain_next = msq_pkg::msq_gain_value(
            cfg_reg[msq_pkg::GAIN_LSB +: 5]); // [RULE7]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg <= msq_pkg::CFG_RESET;
            single_pass_reg <= 1'b0;
            tgl_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            gain_reg <= 11'h000;
        end else begin
            cfg_reg <= cfg_next;
            single_pass_reg <= single_pass_next;
            tgl_reg <= tgl_next;
            wr_pend_reg <= wr_pend_next;
            addr_reg <= addr_next;
            hrdata <= hrdata_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            gain_reg <= gain_next;
        end
    end

    // Link reset: asserted with hresetn, released on link edges
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            rst_l_meta <= 1'b0;
            rst_l_n <= 1'b0;
        end else begin
            rst_l_meta <= 1'b1;
            rst_l_n <= rst_l_meta;
        end
    end

    msq_cfg_cross #(.W(msq_pkg::XFER_W)) u_cross (
        .clk(link_clk),
        .rst_n(rst_l_n),
        .cfg(cfg_bus),
        .word_q(xw),
        .load_pulse(load_pulse)
    );

    msq_sync2 #(.W(4)) u_pins (
        .clk(link_clk),
        .rst_n(rst_l_n),
        // Clock pins inverted so the cleared stages match their idle level
        .d({!scan_clock_n, !backplane_trigger_line, scan_entry, scan_list_end}),
        .q(pins_s)
    );

    // Count is set up before the entry strobe, so plain level sync suffices
    msq_sync2 #(.W(8)) u_count (
        .clk(link_clk),
        .rst_n(rst_l_n),
        .d(scan_entry_count),
        .q(count_s)
    );

    msq_sync2 #(.W(7)) u_stat (
        .clk(hclk),
        .rst_n(hresetn),
        .d({stopped_reg, shared_bus_drive_enable, gray_reg}),
        .q(stat_s)
    );

    // Scan-control is not a clock, so it is synchronised like any pin
    logic scon_meta, scon_s;
    always_ff @(posedge link_clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            scon_meta <= 1'b1;
            scon_s <= 1'b1;
        end else begin
            scon_meta <= scan_control_n;
            scon_s <= scon_meta;
        end
    end

    always_comb begin
        mode_l = xw[msq_pkg::MODE_LSB +: 2];
        cfg_zero = load_pulse && (xw[msq_pkg::CFG_W-1:0] == msq_pkg::CFG_RESET);
        sel_clk = (mode_l == msq_pkg::MODE_TRIG)
            ? pins_s[2] : pins_s[3]; // [RULE3] [RULE5]
        adv_edge = sel_clk && !clk_d_reg;
        entry_rise = pins_s[1] && !entry_d_reg;
        end_rise = pins_s[0] && !end_d_reg;
        scanned = xw[msq_pkg::SCEN_BIT] && !stopped_reg
            && (mode_l == msq_pkg::MODE_DIRECT || mode_l == msq_pkg::MODE_TRIG);
        chan_next = channel_counter;
        samples_next = samples_reg;
        stopped_next = stopped_reg;
        if (cfg_zero) begin
            chan_next = msq_pkg::CHAN_FIRST; // [RULE2]
            samples_next = 9'h000;
        end else if (entry_rise) begin
            chan_next = xw[msq_pkg::CHAN_LSB +: 5]; // [RULE12]
            samples_next = {1'b0, count_s} + 9'h001; // [RULE14]
        end else if (scanned && !scon_s && adv_edge && samples_reg != 9'h000) begin
            chan_next = (channel_counter == msq_pkg::CHAN_LAST)
                ? msq_pkg::CHAN_FIRST : channel_counter + 5'h01; // [RULE13]
            samples_next = samples_reg - 9'h001;
        end
        // Repeat mode ignores the list end; single pass latches a stop
        // A list end in the same cycle as a rewrite still stops: set wins
        if (end_rise && xw[msq_pkg::CFG_W + msq_pkg::SINGLE_PASS_BIT]) begin
            stopped_next = 1'b1; // [RULE10]
        end else if (load_pulse) begin
            stopped_next = 1'b0;
        end
        gray_next = chan_next ^ (chan_next >> 1);
        drive_next = xw[msq_pkg::BUS_EN_BIT] // [RULE1]
            && scanned // [RULE6]
            && !scon_s; // [RULE4] [RULE19]
        route_next = mode_l == msq_pkg::MODE_DIRECT; // [RULE4]
        trig_next = mode_l == msq_pkg::MODE_TRIG; // [RULE5]
    end

    always_ff @(posedge link_clk or negedge rst_l_n) begin
        if (!rst_l_n) begin
            clk_d_reg <= 1'b0;
            entry_d_reg <= 1'b0;
            end_d_reg <= 1'b0;
            channel_counter <= msq_pkg::CHAN_FIRST;
            gray_reg <= 5'h00;
            samples_reg <= 9'h000;
            stopped_reg <= 1'b0;
            shared_bus_drive_enable <= 1'b0;
            analog_output_channel_zero <= 1'b0;
            trigger_clock_select <= 1'b0;
        end else begin
            clk_d_reg <= sel_clk;
            entry_d_reg <= pins_s[1];
            end_d_reg <= pins_s[0];
            channel_counter <= chan_next;
            gray_reg <= gray_next;
            samples_reg <= samples_next;
            stopped_reg <= stopped_next;
            shared_bus_drive_enable <= drive_next;
            analog_output_channel_zero <= route_next;
            trigger_clock_select <= trig_next;
        end
    end

    property p_zero_cfg;
        @(posedge hclk) disable iff (!hresetn)
        wr_pend_reg && addr_reg == msq_pkg::ADDR_CONFIG && hwdata == 32'h0
        |=> cfg_reg == msq_pkg::CFG_RESET;
    endproperty
    a_zero_cfg: assert property (p_zero_cfg) else $error("zero write kept cfg"); // [RULE2]

    property p_gain50;
        @(posedge hclk) disable iff (!hresetn)
        cfg_reg[msq_pkg::GAIN_LSB +: 5] == 5'h09 |=> gain_reg == 11'h032;
    endproperty
    a_gain50: assert property (p_gain50) else $error("gain 50 misdecoded"); // [RULE7]

    property p_no_en;
        @(posedge link_clk) disable iff (!rst_l_n)
        !xw[msq_pkg::BUS_EN_BIT] |=> !shared_bus_drive_enable;
    endproperty
    a_no_en: assert property (p_no_en) else $error("drive without enable"); // [RULE1]

    property p_scen_off;
        @(posedge link_clk) disable iff (!rst_l_n)
        !xw[msq_pkg::SCEN_BIT] |=> !shared_bus_drive_enable;
    endproperty
    a_scen_off: assert property (p_scen_off) else $error("drive with scen 0"); // [RULE6]

    property p_idle_off;
        @(posedge link_clk) disable iff (!rst_l_n)
        scon_s [*2] |=> !shared_bus_drive_enable;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("drive while idle"); // [RULE19]

    property p_reload;
        @(posedge link_clk) disable iff (!rst_l_n)
        entry_rise && !cfg_zero
        |=> channel_counter == $past(xw[msq_pkg::CHAN_LSB +: 5])
            && samples_reg == {1'b0, $past(count_s)} + 9'h001;
    endproperty
    a_reload: assert property (p_reload) else $error("entry not reloaded"); // [RULE12]

    property p_wrap;
        @(posedge link_clk) disable iff (!rst_l_n)
        !cfg_zero && !entry_rise && scanned && !scon_s && adv_edge
        && samples_reg != 9'h000 && channel_counter == 5'h1F
        |=> channel_counter == 5'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("channel did not wrap"); // [RULE13]

    property p_modes;
        @(posedge link_clk) disable iff (!rst_l_n)
        mode_l == msq_pkg::MODE_TRIG
        |=> trigger_clock_select && !analog_output_channel_zero;
    endproperty
    a_modes: assert property (p_modes) else $error("mode 01 outputs wrong"); // [RULE5]

    property p_stop;
        @(posedge link_clk) disable iff (!rst_l_n)
        stopped_reg && !load_pulse |=> !shared_bus_drive_enable && stopped_reg;
    endproperty
    a_stop: assert property (p_stop) else $error("single pass not held"); // [RULE10]

    c_drive: cover property (@(posedge link_clk) shared_bus_drive_enable);
    c_wrap: cover property (@(posedge link_clk)
        channel_counter == 5'h1F ##1 channel_counter == 5'h00);
    c_entry: cover property (@(posedge link_clk) entry_rise);
    c_stop: cover property (@(posedge link_clk) $rose(stopped_reg));
endmodule : msq_scan_module

// ==== msq_pkg.sv ====
// Shared constants for the multiplexed scan sequencer
package msq_pkg;
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam int CFG_W = 24;
    localparam int XFER_W = 25;
    localparam int BUS_EN_BIT = 0;
    localparam int SCEN_BIT = 2;
    localparam int CHAN_LSB = 8;
    localparam int MODE_LSB = 14;
    localparam int GAIN_LSB = 16;
    localparam int SINGLE_PASS_BIT = 0;
    localparam int STAT_DRIVE_BIT = 8;
    localparam int STAT_STOP_BIT = 9;
    localparam int STAT_GAIN_LSB = 16;
    localparam logic [1:0] MODE_DIRECT = 2'h2;
    localparam logic [1:0] MODE_TRIG = 2'h1;
    localparam logic [7:0] LOW_BYTE_MULTI = 8'h07;
    localparam logic [4:0] CHAN_LAST = 5'h1F;
    localparam logic [4:0] CHAN_FIRST = 5'h00;
    localparam logic [4:0] GAIN_CODE_1 = 5'h00;
    localparam logic [4:0] GAIN_CODE_50 = 5'h09;
    localparam logic [4:0] GAIN_CODE_2000 = 5'h12;
    localparam logic [10:0] GAIN_VAL_1 = 11'h001;
    localparam logic [10:0] GAIN_VAL_50 = 11'h032;
    localparam logic [10:0] GAIN_VAL_2000 = 11'h7D0;
    localparam logic [CFG_W-1:0] CFG_RESET = 24'h000000;

    function automatic logic [10:0] msq_gain_value(input logic [4:0] code);
        logic [10:0] v;
        v = 11'h000;
        case (code)
            GAIN_CODE_1: v = GAIN_VAL_1;
            GAIN_CODE_50: v = GAIN_VAL_50;
            GAIN_CODE_2000: v = GAIN_VAL_2000;
            default: v = 11'h000;
        endcase
        return v;
    endfunction : msq_gain_value
endpackage : msq_pkg

// ==== msq_cfg_if.sv ====
// Configuration word carried from the bus domain to the link domain
`timescale 1ns/1ns
interface msq_cfg_if #(parameter int W = 25);
    logic [W-1:0] word;
    logic load_tgl;
    modport src (output word, output load_tgl);
    modport dst (input word, input load_tgl);
endinterface : msq_cfg_if

// ==== msq_sync2.sv ====
// Two-stage level synchroniser
`timescale 1ns/1ns
module msq_sync2 #(parameter int W = 1) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : msq_sync2

// ==== msq_cfg_cross.sv ====
// Toggle handshake that lands a configuration word in the link domain
`timescale 1ns/1ns
module msq_cfg_cross #(parameter int W = 25) (
    input wire logic clk,
    input wire logic rst_n,
    msq_cfg_if.dst cfg,
    output logic [W-1:0] word_q,
    output logic load_pulse
);
    logic tgl_s;
    logic tgl_d_reg;
    logic [W-1:0] word_next;
    msq_sync2 #(.W(1)) u_tgl (
        .clk(clk), .rst_n(rst_n), .d(cfg.load_tgl), .q(tgl_s)
    );
    // Word is held by the source for many link cycles after a toggle
    always_comb begin
        word_next = (tgl_s != tgl_d_reg) ? cfg.word : word_q;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_d_reg <= 1'b0;
            word_q <= '0;
            load_pulse <= 1'b0;
        end else begin
            tgl_d_reg <= tgl_s;
            word_q <= word_next;
            load_pulse <= tgl_s != tgl_d_reg;
        end
    end
endmodule : msq_cfg_cross

// ==== msq_host_model.sv ====
// Host acquisition board model driving the scan pins
`timescale 1ns/1ns
module msq_host_model (
    input wire logic link_clk,
    output logic scan_clock_n,
    output logic backplane_trigger_line,
    output logic scan_control_n,
    output logic scan_entry,
    output logic [7:0] scan_entry_count,
    output logic scan_list_end
);
    initial begin
        scan_clock_n = 1'b1;
        backplane_trigger_line = 1'b1;
        scan_control_n = 1'b1;
        scan_entry = 1'b0;
        scan_entry_count = 8'hA5;
        scan_list_end = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge link_clk);
    endtask : tick
    task automatic set_control(input logic v);
        tick(1);
        scan_control_n <= v;
        tick(6);
    endtask : set_control
    // One entry per frame, entry line low between entries
    task automatic send_entry(input int samples);
        tick(1);
        scan_entry_count <= 8'(samples - 1);
        tick(4);
        scan_entry <= 1'b1;
        tick(4);
        scan_entry <= 1'b0;
        tick(4);
        // Released count wanders so a stale latch shows up
        scan_entry_count <= ~scan_entry_count;
    endtask : send_entry
    // Clocks idle high outside frames
    task automatic pulse(input logic use_trig, input int n);
        repeat (n) begin
            tick(1);
            if (use_trig) backplane_trigger_line <= 1'b0;
            else scan_clock_n <= 1'b0;
            tick(3);
            backplane_trigger_line <= 1'b1;
            scan_clock_n <= 1'b1;
            tick(2);
        end
    endtask : pulse
    task automatic end_list();
        tick(1);
        scan_list_end <= 1'b1;
        tick(4);
        scan_list_end <= 1'b0;
        tick(4);
    endtask : end_list
endmodule : msq_host_model

// ==== tb_top.sv ====
// Self-checking bench for the scanned amplifier module
`timescale 1ns/1ns
module tb_top;
    logic hclk = 1'b0;
    logic link_clk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, drive, ch0_out, trig_sel;
    logic sck_n, trg, sc_n, ent, lend;
    logic [7:0] ent_cnt;
    logic [4:0] chan;
    logic rd_phase = 1'b0;
    logic [31:0] exp_q[$];
    logic [7:0] pin_q[$];
    logic [15:0] lfsr = 16'h001E;
    logic [4:0] gcode[3] = '{5'h00, 5'h09, 5'h12};
    logic [10:0] gval[3] = '{11'h001, 11'h032, 11'h7D0};
    event pin_ev;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #10 hclk = ~hclk;
    // Odd offset keeps link edges off the bus clock edges
    initial begin
        #3;
        forever #16 link_clk = ~link_clk;
    end
    msq_scan_module i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
        .scan_clock_n(sck_n), .backplane_trigger_line(trg),
        .scan_control_n(sc_n), .scan_entry(ent),
        .scan_entry_count(ent_cnt), .scan_list_end(lend),
        .shared_bus_drive_enable(drive),
        .analog_output_channel_zero(ch0_out),
        .trigger_clock_select(trig_sel), .channel_counter(chan));
    msq_host_model i_host (.link_clk(link_clk), .scan_clock_n(sck_n),
        .backplane_trigger_line(trg), .scan_control_n(sc_n),
        .scan_entry(ent), .scan_entry_count(ent_cnt),
        .scan_list_end(lend));
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic logic [31:0] cfg(input logic [4:0] g,
            input logic [1:0] m, input logic [4:0] c, input logic [7:0] lo);
        return {11'h000, g, m, 1'b0, c, lo};
    endfunction : cfg
    function automatic logic [31:0] st(input logic [4:0] c, input logic d,
            input logic s, input logic [10:0] g);
        return {5'h00, g, 6'h00, s, d, 3'h0, c};
    endfunction : st
    task automatic cmp(input string what, input logic [31:0] e,
            input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic print_verdict();
        $display("Checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic lw(input int n);
        repeat (n) @(posedge link_clk);
    endtask : lw
    task automatic addr_phase(input logic [31:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask : addr_phase
    task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
    endtask : bus_write
    task automatic bus_read(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr_phase(a, 1'b0);
        rd_phase <= 1'b1;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd_phase <= 1'b0;
    endtask : bus_read
    // Expected pins: drive, board route, trigger clock, channel
    task automatic pins(input logic [7:0] e);
        pin_q.push_back(e);
        -> pin_ev;
    endtask : pins
    always @(posedge hclk) begin
        if (rd_phase) begin
            cmp("ready", 32'h1, {31'h0, hreadyout});
            cmp("read", exp_q.pop_front(), hrdata);
            cmp("resp", 32'h0, {31'h0, hresp});
        end
    end
    always @(pin_ev) begin
        cmp("pins", {24'h0, pin_q.pop_front()},
            {24'h0, drive, ch0_out, trig_sel, chan});
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        logic [4:0] s0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        lw(6);
        bus_read(32'(msq_pkg::ADDR_CONFIG), 32'h0);
        bus_write(32'h0C, {lfsr, lfsr});
        bus_read(32'h0C, 32'h0);
        i_host.set_control(1'b0);
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            s0 = lfsr[4:0];
            bus_write(32'(msq_pkg::ADDR_CONFIG),
                cfg(gcode[i], msq_pkg::MODE_DIRECT, s0, 8'h07));
            lw(10);
            i_host.send_entry(7);
            i_host.pulse(1'b0, 9);
            pins({3'b110, 5'(s0 + 5'd7)});
            bus_read(32'(msq_pkg::ADDR_STATUS),
                st(5'(s0 + 5'd7), 1'b1, 1'b0, gval[i]));
            i_host.set_control(1'b1);
            pins({3'b010, 5'(s0 + 5'd7)});
            i_host.set_control(1'b0);
        end
        bus_write(32'(msq_pkg::ADDR_CONFIG),
            cfg(5'h12, msq_pkg::MODE_TRIG, 5'd28, 8'h07));
        lw(10);
        i_host.send_entry(12);
        i_host.pulse(1'b1, 6);
        // Scan clock pin must be ignored in trigger mode
        i_host.pulse(1'b0, 3);
        pins({3'b101, 5'd2});
        i_host.send_entry(4);
        pins({3'b101, 5'd28});
        // Filler clocks while another chassis is read must not move us
        i_host.set_control(1'b1);
        i_host.pulse(1'b1, 2);
        pins({3'b001, 5'd28});
        i_host.set_control(1'b0);
        bus_write(32'(msq_pkg::ADDR_CONFIG), 32'h0);
        lw(10);
        bus_read(32'(msq_pkg::ADDR_CONFIG), 32'h0);
        pins(8'h00);
        bus_write(32'(msq_pkg::ADDR_CONFIG),
            cfg(5'h09, msq_pkg::MODE_DIRECT, 5'd5, 8'h03));
        lw(10);
        pins({3'b010, 5'd0});
        bus_write(32'(msq_pkg::ADDR_CONFIG),
            cfg(5'h00, msq_pkg::MODE_DIRECT, 5'd0, 8'h06));
        lw(10);
        pins({3'b010, 5'd0});
        bus_write(32'(msq_pkg::ADDR_CONFIG),
            cfg(5'h00, msq_pkg::MODE_DIRECT, 5'd0, 8'h07));
        lw(10);
        bus_write(32'(msq_pkg::ADDR_CTRL), 32'h1);
        lw(10);
        i_host.end_list();
        lw(4);
        bus_read(32'(msq_pkg::ADDR_STATUS),
            st(5'd0, 1'b0, 1'b1, 11'h001));
        pins({3'b010, 5'd0});
        bus_write(32'(msq_pkg::ADDR_CTRL), 32'h0);
        lw(10);
        i_host.end_list();
        pins({3'b110, 5'd0});
        print_verdict();
    end
endmodule : tb_top
